/* pkg/irt_pkg.sv */
/*
  Shared constants for the infrared carrier and modulation timer: register
  offsets, field positions, reset values and the receive state type.
  Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
*/
// What this block does
// - Transmit downcount per carrier cycle or input clock
// - Enabled transmit pin idles at polarity level
// - Data one sends carrier, zero sends idle
// - Transmission starts when enable and transmit meet
// - Settings sampled at start and every reload
// - Zero count reloads, resamples, updates pin, flags
// - Receive select or disable ends transmission
// - Interval lasts modulation time plus one
// - Envelope pin shows data, inverted by polarity
// - Envelope mode picks modulated or free carrier
// - Edge select field picks qualified receive edges
// - Receive count starts from zero at first edge
// - Receive count advances per carrier or input clock
// - Later edges capture level and count, optional clear
// - Count wrap sets overflow flag and interrupt
// - Receive continues until transmit or disable
// - Burst mode counts edges instead of capturing
// - Burst mode flags two carrier cycles without edge
// - Entering burst mode loads modulation time with one
// - Burst mode keeps clock select and reload bit
// - Carrier phases last byte value plus one
// - Disabled timer pin follows manual control bits

package irt_pkg;

  // ==========================================================================
  // Bus and register widths
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned REG_W      = 16;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CARRIER = 8'h04;
  localparam logic [7:0] OFS_MODTIME = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;

  // ==========================================================================
  // Control register fields
  localparam int unsigned CTL_ENABLE   = 0;
  localparam int unsigned CTL_DIR      = 1;
  localparam int unsigned CTL_MCS      = 2;
  localparam int unsigned CTL_POL      = 3;
  localparam int unsigned CTL_DATA     = 4;
  localparam int unsigned CTL_ENV_LO   = 5;
  localparam int unsigned CTL_EDGE_LO  = 7;
  localparam int unsigned CTL_RELOAD   = 9;
  localparam int unsigned CTL_BURST    = 10;
  localparam int unsigned CTL_IE       = 11;
  localparam int unsigned CTL_DIV_LO   = 12;
  localparam int unsigned CTL_MAN_LVL  = 14;
  localparam int unsigned CTL_MAN_OE   = 15;

  // Status register fields
  localparam int unsigned STS_INTERVAL = 0;
  localparam int unsigned STS_OVERFLOW = 1;

  // ==========================================================================
  // Field encodings
  localparam logic [1:0] ENV_MODULATED = 2'h1;
  localparam logic [1:0] ENV_FREE      = 2'h2;
  localparam logic [1:0] EDGE_RISE     = 2'h1;
  localparam logic [1:0] EDGE_FALL     = 2'h2;
  localparam logic [1:0] EDGE_BOTH     = 2'h3;

  // ==========================================================================
  // Reset values and fixed loads
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] CARRIER_RST = 16'h0000;
  localparam logic [15:0] MODTIME_RST = 16'h0000;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] BURST_LOAD  = 16'h0001;
  localparam logic [1:0]  GAP_CYCLES  = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Receive sequencing
  typedef enum logic [1:0] {RX_OFF, RX_ARMED, RX_RUN} irt_rx_t;

endpackage : irt_pkg

/* hw/irt_carrier.sv */
/*
  Carrier generator: a high phase and a low phase, each counted in input
  clock ticks, with the phase lengths latched on a load pulse.
  Assumes tick is a one-cycle pulse on the same clock as everything else.
*/
`timescale 1ns/1ps

module irt_carrier (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic [7:0] high_byte,
  input  wire logic [7:0] low_byte,
  output logic            carrier,
  output logic            cycle_end
);
  import irt_pkg::*;

  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [7:0] cnt_q;
  logic       phase_q;
  logic       hi_done;
  logic       lo_done;

  // ==========================================================================
  // Phase decode
  assign hi_done   = phase_q && (cnt_q == hi_q);
  assign lo_done   = !phase_q && (cnt_q == lo_q);
  assign cycle_end = ce && tick && lo_done;
  assign carrier   = phase_q;

  // Load restarts the cycle at its high phase so a new period starts clean
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_q    <= 8'h00;
      lo_q    <= 8'h00;
      cnt_q   <= 8'h00;
      phase_q <= 1'b1;
    end else if (ce) begin
      if (load) begin
        hi_q    <= high_byte;
        lo_q    <= low_byte;
        cnt_q   <= 8'h00;
        phase_q <= 1'b1;
      end else if (tick) begin
        if (hi_done || lo_done) begin
          cnt_q   <= 8'h00;
          phase_q <= !phase_q;
        end else begin
          cnt_q   <= cnt_q + 8'h01;
        end
      end
    end
  end

endmodule : irt_carrier

/* hw/irt_timer.sv */
/*
  Infrared carrier and modulation timer: transmit modulator, envelope
  output, receive edge capture with burst counting, and an AXI4-Lite slave.
  Assumes a synchronous AXI4-Lite master on clock; receive_pin is async.
*/
`timescale 1ns/1ps

module irt_timer (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic [irt_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [irt_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [irt_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [irt_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic                               transmit_pin,
  output logic                               transmit_pin_oe,
  output logic                               envelope_pin,
  input  wire logic                          receive_pin,
  output logic                               irq
);
  import irt_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) r[7:0] = new_v[7:0];
    if (strb[1]) r[15:8] = new_v[15:8];
    return r;
  endfunction : merge16

  function automatic logic [2:0] div_mask(input logic [1:0] div);
    logic [2:0] m;
    m = 3'h0;
    unique case (div)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
    endcase
    return m;
  endfunction : div_mask

  // ==========================================================================
  // State
  logic [15:0] ctrl_q;
  logic [15:0] carrier_q;
  logic [15:0] mt_q;
  logic [15:0] count_q;
  logic [1:0]  flags_q;
  logic        data_q;
  logic [2:0]  div_cnt_q;
  logic        tx_on_q;
  logic        data_l_q;
  logic        pol_l_q;
  irt_rx_t     rx_q;
  logic [1:0]  gap_q;
  logic        rx_s1_q;
  logic        rx_s2_q;
  logic        rx_prev_q;
  logic        tx_pin_q;
  logic        tx_oe_q;
  logic        env_pin_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // ==========================================================================
  // Control fields
  logic       en;
  logic       dir_tx;
  logic       mcs;
  logic       pol;
  logic [1:0] env_mode;
  logic [1:0] edge_sel;
  logic       rx_reload;
  logic       burst;
  logic       env_on;

  assign en        = ctrl_q[CTL_ENABLE];
  assign dir_tx    = ctrl_q[CTL_DIR];
  assign mcs       = ctrl_q[CTL_MCS];
  assign pol       = ctrl_q[CTL_POL];
  assign env_mode  = ctrl_q[CTL_ENV_LO +: 2];
  assign edge_sel  = ctrl_q[CTL_EDGE_LO +: 2];
  assign rx_reload = ctrl_q[CTL_RELOAD];
  assign burst     = ctrl_q[CTL_BURST];
  assign env_on    = (env_mode == ENV_MODULATED) || (env_mode == ENV_FREE);

  // ==========================================================================
  // Bus write decode; address and data are taken together in one beat
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic        wr_ctrl;
  logic        wr_car;
  logic        wr_mt;
  logic        wr_stat;
  logic        wr_hit;
  logic [15:0] ctrl_new;
  logic        burst_rise;

  assign s_axi_awready = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_wready  = s_axi_awready;
  assign wr_en         = s_axi_awready;
  assign wr_addr       = {s_axi_awaddr[7:2], 2'h0};
  assign wr_ctrl       = wr_en && (wr_addr == OFS_CTRL);
  assign wr_car        = wr_en && (wr_addr == OFS_CARRIER);
  assign wr_mt         = wr_en && (wr_addr == OFS_MODTIME);
  assign wr_stat       = wr_en && (wr_addr == OFS_STATUS);
  assign wr_hit        = (wr_addr == OFS_CTRL) || (wr_addr == OFS_CARRIER) ||
                         (wr_addr == OFS_MODTIME) || (wr_addr == OFS_STATUS) ||
                         (wr_addr == OFS_COUNT);
  assign ctrl_new      = merge16(ctrl_q, s_axi_wdata, s_axi_wstrb);
  assign burst_rise    = wr_ctrl && ctrl_new[CTL_BURST] && !burst;

  // ==========================================================================
  // Input clock divider and carrier
  logic ir_tick;
  logic car_level;
  logic car_end;
  logic car_load;
  logic cnt_tick;

  assign ir_tick  = (div_cnt_q == div_mask(ctrl_q[CTL_DIV_LO +: 2]));
  assign cnt_tick = mcs ? ir_tick : car_end;

  // Divider counts only while the block is enabled so phases line up with start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) div_cnt_q <= 3'h0;
    else if (ce) div_cnt_q <= (ir_tick || !en) ? 3'h0 : div_cnt_q + 3'h1;
  end

  irt_carrier u_carrier (
    .clock     (clock),
    .rst       (rst),
    .ce        (ce),
    .tick      (ir_tick),
    .load      (car_load),
    .high_byte (carrier_q[15:8]),
    .low_byte  (carrier_q[7:0]),
    .carrier   (car_level),
    .cycle_end (car_end)
  );

  // ==========================================================================
  // Transmit sequencing
  logic tx_mode;
  logic tx_start;
  logic tx_run;
  logic tx_reload;

  assign tx_mode   = en && dir_tx;
  assign tx_start  = tx_mode && !tx_on_q;
  assign tx_run    = tx_mode && tx_on_q;
  assign tx_reload = tx_run && cnt_tick && (count_q == COUNT_ZERO);

  // ==========================================================================
  // Receive edge detection; the first sync stage feeds only the second
  logic rx_mode;
  logic rise;
  logic fall;
  logic qual;
  logic rx_edge_run;
  logic gap_hit;

  assign rx_mode     = en && !dir_tx;
  assign rise        = rx_s2_q && !rx_prev_q;
  assign fall        = !rx_s2_q && rx_prev_q;
  assign qual        = ((edge_sel == EDGE_RISE) && rise) ||
                       ((edge_sel == EDGE_FALL) && fall) ||
                       ((edge_sel == EDGE_BOTH) && (rise || fall));
  assign rx_edge_run = rx_mode && (rx_q == RX_RUN) && qual;
  assign gap_hit     = rx_mode && (rx_q == RX_RUN) && burst && !qual && car_end &&
                       (gap_q == GAP_CYCLES - 2'h1);
  assign car_load    = tx_start || tx_reload || (rx_mode && (rx_q == RX_OFF));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_s1_q   <= 1'b1;                // Idle high, so no false edge after reset
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (ce) begin
      rx_s1_q   <= receive_pin;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  // Receive state: armed on entry, running from the first qualified edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rx_q <= RX_OFF;
    else if (ce) begin
      if (!rx_mode) rx_q <= RX_OFF;
      else if (rx_q == RX_OFF) rx_q <= RX_ARMED;
      else if (rx_q == RX_ARMED && qual) rx_q <= RX_RUN;
    end
  end

  // Gap counter in carrier cycles since the last qualified edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) gap_q <= 2'h0;
    else if (ce) begin
      if (qual || rx_q != RX_RUN) gap_q <= 2'h0;
      else if (car_end && gap_q != GAP_CYCLES) gap_q <= gap_q + 2'h1;
    end
  end

  // ==========================================================================
  // Count value: downcounter in transmit, upcounter in receive
  logic overflow_hit;

  assign overflow_hit = rx_mode && (rx_q == RX_RUN) && cnt_tick &&
                        (count_q == COUNT_MAX) && !(qual && rx_reload);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) count_q <= COUNT_ZERO;
    else if (ce) begin
      if (tx_start || tx_reload) count_q <= mt_q;
      else if (tx_run && cnt_tick) count_q <= count_q - 16'h0001;
      else if (rx_mode && rx_q == RX_ARMED && qual) count_q <= COUNT_ZERO;
      else if (rx_edge_run && rx_reload) count_q <= COUNT_ZERO;
      else if (rx_mode && rx_q == RX_RUN && cnt_tick) count_q <= count_q + 16'h0001;
    end
  end

  // Modulation time: software, receive capture, or burst edge counting
  always_ff @(posedge clock or posedge rst) begin
    if (rst) mt_q <= MODTIME_RST;
    else if (ce) begin
      if (burst_rise) mt_q <= BURST_LOAD;
      else if (rx_edge_run && burst) mt_q <= mt_q + 16'h0001;
      else if (rx_edge_run) mt_q <= count_q;
      else if (wr_mt) mt_q <= merge16(mt_q, s_axi_wdata, s_axi_wstrb);
    end
  end

  // Data bit: software value, overwritten by the captured pin level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) data_q <= CTRL_RST[CTL_DATA];
    else if (ce) begin
      if (rx_edge_run && !burst) data_q <= rx_s2_q;
      else if (wr_ctrl && s_axi_wstrb[0]) data_q <= s_axi_wdata[CTL_DATA];
    end
  end

  // Transmit sample latches, refreshed at start and at every reload
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_on_q  <= 1'b0;
      data_l_q <= 1'b0;
      pol_l_q  <= 1'b0;
    end else if (ce) begin
      tx_on_q <= tx_mode;
      if (tx_start || tx_reload) begin
        data_l_q <= data_q;
        pol_l_q  <= pol;
      end
    end
  end

  // ==========================================================================
  // Pin drivers, registered so the pins never glitch on decode
  logic tx_mod;
  logic tx_free;
  logic tx_d;

  assign tx_mod  = data_l_q ? (car_level ^ pol_l_q) : pol_l_q;
  assign tx_free = car_level ^ pol_l_q;
  assign tx_d    = !en ? ctrl_q[CTL_MAN_LVL] :
                   !tx_on_q ? pol :
                   (env_mode == ENV_FREE) ? tx_free : tx_mod;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_pin_q  <= 1'b0;
      tx_oe_q   <= 1'b0;
      env_pin_q <= 1'b0;
    end else if (ce) begin
      tx_pin_q <= tx_d;
      tx_oe_q  <= en || ctrl_q[CTL_MAN_OE];
      if (!env_on) env_pin_q <= 1'b0;
      else if (tx_start || tx_reload) env_pin_q <= data_q ^ pol;
    end
  end

  assign transmit_pin    = tx_pin_q;
  assign transmit_pin_oe = tx_oe_q;
  assign envelope_pin    = env_pin_q;

  // ==========================================================================
  // Software registers; a flag set in the clearing cycle survives
  logic       interval_set;
  logic [1:0] flag_clr;

  assign interval_set = tx_reload || (rx_edge_run && !burst) || gap_hit;
  assign flag_clr     = (wr_stat && s_axi_wstrb[0]) ? s_axi_wdata[1:0] : 2'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q    <= CTRL_RST;
      carrier_q <= CARRIER_RST;
      flags_q   <= 2'h0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_q <= ctrl_new;
      if (wr_car) carrier_q <= merge16(carrier_q, s_axi_wdata, s_axi_wstrb);
      flags_q[STS_INTERVAL] <= (flags_q[STS_INTERVAL] && !flag_clr[STS_INTERVAL]) ||
                               interval_set;
      flags_q[STS_OVERFLOW] <= (flags_q[STS_OVERFLOW] && !flag_clr[STS_OVERFLOW]) ||
                               overflow_hit;
    end
  end

  assign irq = ctrl_q[CTL_IE] && (|flags_q);

  // ==========================================================================
  // Bus read mux and response channels
  logic [7:0]  rd_addr;
  logic [15:0] rd_val;
  logic        rd_hit;
  logic        rd_en;

  assign s_axi_arready = ce && !rvalid_q;
  assign rd_en         = s_axi_arready && s_axi_arvalid;
  assign rd_addr       = {s_axi_araddr[7:2], 2'h0};
  assign rd_hit        = (rd_addr == OFS_CTRL) || (rd_addr == OFS_CARRIER) ||
                         (rd_addr == OFS_MODTIME) || (rd_addr == OFS_COUNT) ||
                         (rd_addr == OFS_STATUS);
  assign rd_val        = (rd_addr == OFS_CTRL)    ? {ctrl_q[15:5], data_q, ctrl_q[3:0]} :
                         (rd_addr == OFS_CARRIER) ? carrier_q :
                         (rd_addr == OFS_MODTIME) ? mt_q :
                         (rd_addr == OFS_COUNT)   ? count_q :
                         (rd_addr == OFS_STATUS)  ? {14'h0000, flags_q} : 16'h0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else if (ce) begin
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) bvalid_q <= 1'b0;
      if (rd_en) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= {16'h0000, rd_val};
      end else if (s_axi_rready) rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

endmodule : irt_timer

/* verification/irt_timer_props.sv */
/* Checker for irt_timer: bus answers and pin levels.
   Assumes full-word writes to the control register. */
`timescale 1ns/1ps
module irt_timer_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        transmit_pin,
  input wire logic        transmit_pin_oe,
  input wire logic        envelope_pin,
  input wire logic        irq
);
  import irt_pkg::*;
  logic [15:0] ctrl_q;
  logic [1:0]  age_q;
  wire         take = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  wire         ok   = age_q == 2'h3;
  // ==========================================================
  // Control shadow; pins lag the register, so wait until settled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= 16'h0000;
      age_q  <= 2'h0;
    end else if (take && s_axi_awaddr == OFS_CTRL) begin
      ctrl_q <= s_axi_wdata[15:0];
      age_q  <= 2'h0;
    end else if (!ok) begin
      age_q  <= age_q + 2'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // Properties
  chk_write_answer: assert property (take |=> s_axi_bvalid) else $error("no write answer");
  chk_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer changed");
  chk_manual_pin:
    assert property (ok && !ctrl_q[0] |-> transmit_pin_oe == ctrl_q[15]
      && (!ctrl_q[15] || transmit_pin == ctrl_q[14])) else $error("manual pin wrong");
  chk_drive_on:
    assert property (ok && ctrl_q[0] |-> transmit_pin_oe) else $error("pin not driven");
  chk_env_idle:
    assert property (ok && ctrl_q[6] == ctrl_q[5] |-> !envelope_pin) else $error("envelope set");
  chk_irq_masked:
    assert property (ok && !ctrl_q[11] |-> !irq) else $error("masked irq raised");
endmodule : irt_timer_props
bind irt_timer irt_timer_props irt_timer_props_i (.clock(clock), .rst(rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .transmit_pin(transmit_pin), .transmit_pin_oe(transmit_pin_oe),
  .envelope_pin(envelope_pin), .irq(irq));

/* verification/irt_ir_partner.sv */
/* Far side of the IR link: receiver output and emitter observer.
   Assumes the bench calls drive and reads rises. */
`timescale 1ns/1ps
module irt_ir_partner (
  input  wire logic clock,
  input  wire logic transmit_pin,
  input  wire logic transmit_pin_oe,
  output logic      receive_pin
);
  logic rx_q = 1'b1;
  logic last_q = 1'b0;
  int   rises = 0;
  // Demodulator output idles high, as behind a pull-up
  assign receive_pin = rx_q;
  // Rising edges count only while the emitter is driven
  always @(posedge clock) begin
    if (transmit_pin_oe && transmit_pin && !last_q) rises <= rises + 1;
    last_q <= transmit_pin;
  end
  task automatic drive(input logic v);
    @(posedge clock);
    rx_q <= v;
  endtask : drive
endmodule : irt_ir_partner

/* verification/testbench.sv */
/* Bench for irt_timer: register rows, transmit rows, receive cases.
   Assumes package, design, partner and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module testbench;
  import irt_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;
    logic [1:0] r;} irt_reg_t;
  typedef struct {logic [31:0] c; logic env; logic tog; logic p;} irt_pin_t;
  irt_reg_t regs[5] = '{'{OFS_CARRIER, 32'hFFFF5678, 4'hF, 32'h5678, RESP_OKAY},
    '{OFS_MODTIME, 32'h1234, 4'h2, 32'h1200, RESP_OKAY},
    '{OFS_COUNT, 32'hBEEF, 4'hF, 32'h0, RESP_OKAY},
    '{OFS_STATUS, 32'h3, 4'hF, 32'h0, RESP_OKAY},
    '{8'h20, 32'hFFFF, 4'hF, 32'h0, RESP_SLVERR}};
  irt_pin_t pins[5] = '{'{32'h0B, 0, 0, 1}, '{32'h13, 0, 1, 0}, '{32'h4B, 1, 1, 0},
    '{32'h33, 1, 1, 0}, '{32'h23, 0, 0, 0}};
  logic        clock = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat;
  logic [3:0]  ws = 0;
  logic [1:0]  resp;
  wire         awr, wr_r, bv, arr, rv, tx, oe, env, rx, irq;
  wire [1:0]   br, rr;
  wire [31:0]  rd_d;
  int          err_total = 0, cmp_count = 0, cyc = 0, t0, r0;
  irt_timer irt_timer_i (.clock(clock), .rst(rst), .ce(1'b1), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .transmit_pin(tx), .transmit_pin_oe(oe), .envelope_pin(env), .receive_pin(rx), .irq(irq));
  irt_ir_partner partner_i (.clock(clock), .transmit_pin(tx), .transmit_pin_oe(oe),
    .receive_pin(rx));
  // ==========================================================
  // Clock, cycle count and watchdog
  initial forever #4 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    end_of_test();
  end
  // ==========================================================
  // Bus tasks: hold each request until its ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clock);
    awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1;
    do @(posedge clock); while (awr !== 1'b1);
    awv <= 0; wv <= 0;
    @(posedge clock);
    bre <= 1;
    do @(posedge clock); while (bv !== 1'b1);
    resp = br; bre <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    ara <= a; arv <= 1;
    do @(posedge clock); while (arr !== 1'b1);
    arv <= 0;
    @(posedge clock);
    rre <= 1;
    do @(posedge clock); while (rv !== 1'b1);
    rdat = rd_d; resp = rr; rre <= 0;
  endtask : rd
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    `CHK({tx, oe, env, irq}, 4'h0)
    foreach (regs[i]) begin
      rd(regs[i].a);
      `CHK(rdat, 32'h0)
      wr(regs[i].a, regs[i].d, regs[i].s);
      `CHK(resp, regs[i].r)
      rd(regs[i].a);
      `CHK({resp, rdat}, {regs[i].r, regs[i].e})
    end
    wr(OFS_CARRIER, 32'h0101);
    wr(OFS_MODTIME, 32'h3);
    foreach (pins[i]) begin
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, pins[i].c);
      repeat (3) @(posedge clock);
      r0 = partner_i.rises;
      repeat (40) @(posedge clock);
      `CHK(env, pins[i].env)
      `CHK(partner_i.rises != r0, pins[i].tog)
      if (!pins[i].tog) `CHK(tx, pins[i].p)
    end
    wr(OFS_CTRL, 32'hC000);
    repeat (2) @(posedge clock);
    `CHK({tx, oe}, 2'h3)
    wr(OFS_STATUS, 32'h3);
    wr(OFS_CTRL, 32'h0813);
    while (irq !== 1'b1) @(posedge clock);
    t0 = cyc;
    wr(OFS_STATUS, 32'h1);
    while (irq !== 1'b1) @(posedge clock);
    `CHK(cyc - t0, 16)
    wr(OFS_CTRL, 32'h0801);
    wr(OFS_STATUS, 32'h1);
    repeat (40) @(posedge clock);
    `CHK(irq, 1'b0)
    wr(OFS_CTRL, 32'h0385);
    partner_i.drive(0);
    repeat (20) @(posedge clock);
    partner_i.drive(1);
    repeat (8) @(posedge clock);
    rd(OFS_MODTIME);
    `CHK(rdat >= 19 && rdat <= 21, 1'b1)
    rd(OFS_CTRL);
    `CHK(rdat[CTL_DATA], 1'b1)
    wr(OFS_STATUS, 32'h1);
    repeat (65540) @(posedge clock);
    rd(OFS_STATUS);
    `CHK(rdat[1:0], 2'h2)
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS);
    `CHK(rdat[1:0], 2'h0)
    wr(OFS_CTRL, 32'h0785);
    rd(OFS_MODTIME);
    `CHK(rdat, 32'h1)
    partner_i.drive(0);
    repeat (20) @(posedge clock);
    rd(OFS_MODTIME);
    `CHK(rdat, 32'h2)
    rd(OFS_STATUS);
    `CHK(rdat[0], 1'b1)
    end_of_test();
  end
endmodule : testbench
